// *** mcfd_pkg.sv ***
// package: register map, field layout and decode constants of the motor configuration block
package mcfd_pkg;

   // ----------------------------------------
   // register port geometry
   // ----------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam logic [15:0] REG_RST = 16'h0000;

   // ----------------------------------------
   // register offsets
   // ----------------------------------------
   localparam logic [7:0] OFS_SPEED_DIR = 8'h08;
   localparam logic [7:0] OFS_ACCEL = 8'h09;
   localparam logic [7:0] OFS_INPUT_TYPE = 8'h0A;
   localparam logic [7:0] OFS_STARTUP = 8'h0B;
   localparam logic [7:0] OFS_P_GAIN = 8'h0C;
   localparam logic [7:0] OFS_I_GAIN = 8'h0D;
   localparam logic [7:0] OFS_OUT_PIN = 8'h0E;
   localparam logic [7:0] OFS_POS_DET = 8'h12;
   localparam logic [7:0] OFS_IN_THR = 8'h15;
   localparam logic [7:0] OFS_RESP = 8'h16;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int B_CLOSED_LOOP = 11;
   localparam int B_CLOCK_KIND = 12;
   localparam int B_ACCEL_SCALE = 13;
   localparam int B_DIRECTION = 14;
   localparam int B_PWM_BAND = 15;
   localparam int B_ANALOG = 11;
   localparam int B_TACH_DIS = 4;
   localparam int F_START_LSB = 10;
   localparam int F_IPD_LSB = 8;
   localparam int F_NUDGE_LSB = 5;
   localparam int F_OFF_LSB = 8;
   localparam int F_RATIO_LSB = 0;

   // ----------------------------------------
   // decode arithmetic
   // ----------------------------------------
   // acceleration in steps of 0.05 Hz/s; coarse scale 3.2 = 64 steps
   localparam int ACC_COARSE_SHIFT = 6;
   // pulse detect limit in mA per code step (0.086 A)
   localparam logic [12:0] IPD_MA_PER_LSB = 13'h0056;
   // nudge amplitude in tenths of a percent
   localparam logic [7:0] NUDGE_STEP = 8'h20;
   localparam logic [7:0] NUDGE_BASE = 8'h18;
   // response ratio legal band
   localparam logic [5:0] RATIO_MIN = 6'h01;
   localparam logic [5:0] RATIO_MAX = 6'h29;
   // speed input off thresholds in percent
   localparam logic [4:0] OFF_PCT_0 = 5'h0A;
   localparam logic [4:0] OFF_PCT_1 = 5'h06;
   localparam logic [4:0] OFF_PCT_2 = 5'h0F;
   localparam logic [4:0] OFF_PCT_3 = 5'h14;

   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [1:0] {
      ST_SIX_PULSE = 2'b00,
      ST_TWO_PULSE = 2'b01,
      ST_NUDGE = 2'b10,
      ST_ALIGN_GO = 2'b11
   } mcfd_start_t;

   typedef struct packed {
      logic [15:0] speed_dir;
      logic [15:0] accel;
      logic [15:0] in_type;
      logic [15:0] startup;
      logic [15:0] p_gain;
      logic [15:0] i_gain;
      logic [15:0] out_pin;
      logic [15:0] pos_det;
      logic [15:0] in_thr;
      logic [15:0] resp;
   } mcfd_regs_t;

endpackage : mcfd_pkg

// *** mcfd_sync_if.sv ***
// interface: raw speed input and its filtered level
`timescale 1ns/1ns
interface mcfd_sync_if;
   logic raw;
   logic level;
   modport filt (input raw, output level);
   modport user (output raw, input level);
endinterface : mcfd_sync_if

// *** mcfd_pin_filter.sv ***
// three-stage pin synchroniser that accepts a change once two stages agree
`timescale 1ns/1ns
module mcfd_pin_filter (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // filtered pin
   mcfd_sync_if.filt sig
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
   } mcfd_flt_st_t;

   mcfd_flt_st_t st_q;
   mcfd_flt_st_t st_d;

   always_comb begin
      st_d = st_q;
      st_d.s1 = sig.raw;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      if (st_q.s2 == st_q.s3) begin
         st_d.lvl = st_q.s3;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign sig.level = st_q.lvl;

endmodule : mcfd_pin_filter

// *** mcfd_top.sv ***
// top: configuration register bank with decode of motor control settings
`timescale 1ns/1ns
module mcfd_top (
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RESETN,
   // register port from the serial management engine
   input wire logic [mcfd_pkg::ADDR_W-1:0] REG_ADDR,
   input wire logic [mcfd_pkg::DATA_W-1:0] REG_WDATA,
   input wire logic REG_WE,
   input wire logic REG_RE,
   output logic [mcfd_pkg::DATA_W-1:0] REG_RDATA,
   output logic REG_RVALID,
   // pins
   input wire logic SPEED_IN_PIN,
   output logic SPEED_IN_LEVEL,
   input wire logic TACH_CORE,
   output logic TACH_OUT,
   // speed and direction settings
   output logic [13:0] ACCEL_RATE,
   output logic CLOSED_LOOP,
   output logic PHASE_ORDER_ABC,
   output logic ANALOG_INPUT,
   output logic CLOCK_INPUT,
   output logic PWM_INPUT,
   output logic PWM_LOW_BAND,
   output logic [5:0] RESPONSE_TC,
   output logic [5:0] CLOCK_RATIO,
   output logic RATIO_RANGE_ERR,
   output logic [4:0] OFF_THRESHOLD_PCT,
   // startup and observer settings
   output mcfd_pkg::mcfd_start_t STARTUP_METHOD,
   output logic [12:0] PULSE_DETECT_CURRENT_LIMIT_MA,
   output logic [7:0] NUDGE_AMPLITUDE,
   output logic [7:0] OBSERVER_PROPORTIONAL_GAIN,
   output logic [7:0] OBSERVER_INTEGRAL_GAIN
);
   import mcfd_pkg::*;

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      mcfd_regs_t regs;
      logic [15:0] rdata;
      logic rvalid;
      logic tach;
      logic [13:0] accel_rate;
      logic closed_loop;
      logic phase_abc;
      logic analog;
      logic clock_in;
      logic pwm_in;
      logic pwm_low;
      logic [5:0] resp_tc;
      logic [5:0] clock_ratio;
      logic ratio_err;
      logic [4:0] off_pct;
      mcfd_start_t start;
      logic [12:0] ipd_ma;
      logic [7:0] nudge;
      logic [7:0] p_gain;
      logic [7:0] i_gain;
      logic past_ok;
   } mcfd_state_t;

   mcfd_state_t st_q;
   mcfd_state_t st_d;
   mcfd_sync_if spd_if ();
   logic [5:0] ratio_f;
   logic ratio_used;

   // ----------------------------------------
   // speed input synchroniser
   // ----------------------------------------
   assign spd_if.raw = SPEED_IN_PIN;

   mcfd_pin_filter u_spd_filter (
      .clk(REF_CLK),
      .rst_n(RESETN),
      .sig(spd_if.filt)
   );

   // ----------------------------------------
   // register access and decode
   // ----------------------------------------
   assign ratio_f = st_q.regs.resp[F_RATIO_LSB +: 6];

   always_comb begin
      st_d = st_q;
      st_d.rvalid = 1'b0;
      st_d.past_ok = 1'b1;
      ratio_used = 1'b0;
      // fields are stored whole so that readback is exact
      if (REG_WE) begin
         case (REG_ADDR)
            OFS_SPEED_DIR: st_d.regs.speed_dir = REG_WDATA;
            OFS_ACCEL: st_d.regs.accel = REG_WDATA;
            OFS_INPUT_TYPE: st_d.regs.in_type = REG_WDATA;
            OFS_STARTUP: st_d.regs.startup = REG_WDATA;
            OFS_P_GAIN: st_d.regs.p_gain = REG_WDATA;
            OFS_I_GAIN: st_d.regs.i_gain = REG_WDATA;
            OFS_OUT_PIN: st_d.regs.out_pin = REG_WDATA;
            OFS_POS_DET: st_d.regs.pos_det = REG_WDATA;
            OFS_IN_THR: st_d.regs.in_thr = REG_WDATA;
            OFS_RESP: st_d.regs.resp = REG_WDATA;
            default: ;
         endcase
      end
      if (REG_RE) begin
         st_d.rvalid = 1'b1;
         case (REG_ADDR)
            OFS_SPEED_DIR: st_d.rdata = st_q.regs.speed_dir;
            OFS_ACCEL: st_d.rdata = st_q.regs.accel;
            OFS_INPUT_TYPE: st_d.rdata = st_q.regs.in_type;
            OFS_STARTUP: st_d.rdata = st_q.regs.startup;
            OFS_P_GAIN: st_d.rdata = st_q.regs.p_gain;
            OFS_I_GAIN: st_d.rdata = st_q.regs.i_gain;
            OFS_OUT_PIN: st_d.rdata = st_q.regs.out_pin;
            OFS_POS_DET: st_d.rdata = st_q.regs.pos_det;
            OFS_IN_THR: st_d.rdata = st_q.regs.in_thr;
            OFS_RESP: st_d.rdata = st_q.regs.resp;
            default: st_d.rdata = REG_RST;
         endcase
      end
      // acceleration in 0.05 Hz/s steps
      if (st_q.regs.speed_dir[B_ACCEL_SCALE]) begin
         st_d.accel_rate = 14'(st_q.regs.accel[7:0]) << ACC_COARSE_SHIFT;
      end else begin
         st_d.accel_rate = 14'(st_q.regs.accel[7:0]);
      end
      st_d.closed_loop = st_q.regs.speed_dir[B_CLOSED_LOOP];
      st_d.phase_abc = st_q.regs.speed_dir[B_DIRECTION];
      st_d.analog = st_q.regs.in_type[B_ANALOG];
      st_d.clock_in = !st_q.regs.in_type[B_ANALOG]
         && st_q.regs.speed_dir[B_CLOCK_KIND];
      st_d.pwm_in = !st_q.regs.in_type[B_ANALOG]
         && !st_q.regs.speed_dir[B_CLOCK_KIND];
      st_d.pwm_low = st_q.regs.speed_dir[B_PWM_BAND];
      // time constant in 1/15 s, silent in open loop
      if (st_q.regs.speed_dir[B_CLOSED_LOOP]) begin
         st_d.resp_tc = ratio_f;
         ratio_used = 1'b1;
      end else begin
         st_d.resp_tc = 6'h00;
      end
      // clock ratio in 0.25 rpm/Hz, only for clock input
      if (st_d.clock_in) begin
         st_d.clock_ratio = ratio_f;
         ratio_used = 1'b1;
      end else begin
         st_d.clock_ratio = 6'h00;
      end
      // flags a ratio outside the legal band while closed loop or clock input uses it
      st_d.ratio_err = ratio_used && (ratio_f < RATIO_MIN || ratio_f > RATIO_MAX);
      case (st_q.regs.in_thr[F_OFF_LSB +: 2])
         2'b00: st_d.off_pct = OFF_PCT_0;
         2'b01: st_d.off_pct = OFF_PCT_1;
         2'b10: st_d.off_pct = OFF_PCT_2;
         2'b11: st_d.off_pct = OFF_PCT_3;
         default: st_d.off_pct = OFF_PCT_0;
      endcase
      // forced high keeps the shared line quiet for the serial bus
      st_d.tach = st_q.regs.out_pin[B_TACH_DIS] | TACH_CORE;
      st_d.start = mcfd_start_t'(st_q.regs.startup[F_START_LSB +: 2]);
      st_d.ipd_ma = 13'(st_q.regs.pos_det[F_IPD_LSB +: 6]) * IPD_MA_PER_LSB;
      // amplitude in tenths of a percent, zero outside nudge start
      if (st_d.start == ST_NUDGE) begin
         st_d.nudge = 8'(st_q.regs.in_thr[F_NUDGE_LSB +: 3]) * NUDGE_STEP
            + NUDGE_BASE;
      end else begin
         st_d.nudge = 8'h00;
      end
      st_d.p_gain = st_q.regs.p_gain[7:0];
      st_d.i_gain = st_q.regs.i_gain[7:0];
   end

   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign REG_RDATA = st_q.rdata;
   assign REG_RVALID = st_q.rvalid;
   assign SPEED_IN_LEVEL = spd_if.level;
   assign TACH_OUT = st_q.tach;
   assign ACCEL_RATE = st_q.accel_rate;
   assign CLOSED_LOOP = st_q.closed_loop;
   assign PHASE_ORDER_ABC = st_q.phase_abc;
   assign ANALOG_INPUT = st_q.analog;
   assign CLOCK_INPUT = st_q.clock_in;
   assign PWM_INPUT = st_q.pwm_in;
   assign PWM_LOW_BAND = st_q.pwm_low;
   assign RESPONSE_TC = st_q.resp_tc;
   assign CLOCK_RATIO = st_q.clock_ratio;
   assign RATIO_RANGE_ERR = st_q.ratio_err;
   assign OFF_THRESHOLD_PCT = st_q.off_pct;
   assign STARTUP_METHOD = st_q.start;
   assign PULSE_DETECT_CURRENT_LIMIT_MA = st_q.ipd_ma;
   assign NUDGE_AMPLITUDE = st_q.nudge;
   assign OBSERVER_PROPORTIONAL_GAIN = st_q.p_gain;
   assign OBSERVER_INTEGRAL_GAIN = st_q.i_gain;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RESETN);

   property p_accel;
      st_q.past_ok |-> ACCEL_RATE == ($past(st_q.regs.speed_dir[B_ACCEL_SCALE])
         ? 14'($past(st_q.regs.accel[7:0])) * 14'h0040
         : 14'($past(st_q.regs.accel[7:0])));
   endproperty
   a_accel: assert property (p_accel) else $error("acceleration decode wrong");

   property p_loop;
      (REG_WE && REG_ADDR == OFS_SPEED_DIR) ##1 !REG_WE
         |=> CLOSED_LOOP == $past(REG_WDATA[B_CLOSED_LOOP], 2);
   endproperty
   a_loop: assert property (p_loop) else $error("loop closure not applied");

   property p_dir;
      (REG_WE && REG_ADDR == OFS_SPEED_DIR) ##1 !REG_WE
         |=> PHASE_ORDER_ABC == $past(REG_WDATA[B_DIRECTION], 2);
   endproperty
   a_dir: assert property (p_dir) else $error("phase order not applied");

   property p_kind;
      st_q.past_ok |-> ANALOG_INPUT + CLOCK_INPUT + PWM_INPUT == 2'h1;
   endproperty
   a_kind: assert property (p_kind) else $error("input kind not one-hot");

   property p_clock;
      st_q.past_ok && $past(st_q.regs.speed_dir[B_CLOCK_KIND])
         && !$past(st_q.regs.in_type[B_ANALOG]) |-> CLOCK_INPUT;
   endproperty
   a_clock: assert property (p_clock) else $error("clock input not selected");

   property p_band;
      st_q.past_ok |-> PWM_LOW_BAND == $past(st_q.regs.speed_dir[B_PWM_BAND]);
   endproperty
   a_band: assert property (p_band) else $error("pwm band wrong");

   property p_tc;
      CLOSED_LOOP ##1 CLOSED_LOOP |-> RESPONSE_TC == $past(ratio_f);
   endproperty
   a_tc: assert property (p_tc) else $error("time constant wrong");

   property p_open;
      st_q.past_ok && !$past(st_q.regs.speed_dir[B_CLOSED_LOOP]) |-> RESPONSE_TC == 6'h00;
   endproperty
   a_open: assert property (p_open) else $error("open loop used response field");

   property p_ratio;
      st_q.past_ok |-> CLOCK_RATIO == (CLOCK_INPUT ? $past(ratio_f) : 6'h00);
   endproperty
   a_ratio: assert property (p_ratio) else $error("clock ratio wrong");

   property p_range;
      st_q.past_ok && (CLOCK_INPUT || CLOSED_LOOP) && $past(ratio_f) == 6'h00
         |-> RATIO_RANGE_ERR;
   endproperty
   a_range: assert property (p_range) else $error("zero ratio not flagged");

   property p_off;
      st_q.past_ok && $past(st_q.regs.in_thr[F_OFF_LSB +: 2]) == 2'b01
         |-> OFF_THRESHOLD_PCT == 5'h06;
   endproperty
   a_off: assert property (p_off) else $error("off threshold wrong");

   property p_tach;
      st_q.past_ok && $past(st_q.regs.out_pin[B_TACH_DIS]) |-> TACH_OUT;
   endproperty
   a_tach: assert property (p_tach) else $error("tach not held high");

   property p_start;
      (REG_WE && REG_ADDR == OFS_STARTUP) ##1 !REG_WE
         |=> STARTUP_METHOD == $past(REG_WDATA[F_START_LSB +: 2], 2);
   endproperty
   a_start: assert property (p_start) else $error("startup method wrong");

   property p_ipd;
      st_q.past_ok |-> PULSE_DETECT_CURRENT_LIMIT_MA
         == 13'($past(st_q.regs.pos_det[F_IPD_LSB +: 6])) * 13'h0056;
   endproperty
   a_ipd: assert property (p_ipd) else $error("detect limit wrong");

   property p_nudge;
      STARTUP_METHOD == ST_NUDGE |-> NUDGE_AMPLITUDE >= 8'h18 && NUDGE_AMPLITUDE <= 8'hF8;
   endproperty
   a_nudge: assert property (p_nudge) else $error("nudge amplitude out of band");

   property p_pg;
      (REG_WE && REG_ADDR == OFS_P_GAIN) ##1 !REG_WE
         |=> OBSERVER_PROPORTIONAL_GAIN == $past(REG_WDATA[7:0], 2);
   endproperty
   a_pg: assert property (p_pg) else $error("p gain not applied");

   property p_ig;
      (REG_WE && REG_ADDR == OFS_I_GAIN) ##1 !REG_WE
         |=> OBSERVER_INTEGRAL_GAIN == $past(REG_WDATA[7:0], 2);
   endproperty
   a_ig: assert property (p_ig) else $error("i gain not applied");

   property p_readback;
      (REG_WE && REG_ADDR == OFS_RESP) ##1 (REG_RE && !REG_WE && REG_ADDR == OFS_RESP)
         |=> REG_RVALID && REG_RDATA == $past(REG_WDATA, 2);
   endproperty
   a_readback: assert property (p_readback) else $error("readback differs");

   c_nudge: cover property (STARTUP_METHOD == ST_NUDGE ##1 NUDGE_AMPLITUDE != 8'h00);
   c_clock: cover property (CLOCK_INPUT && CLOCK_RATIO != 6'h00);
   c_tach: cover property (TACH_OUT && !TACH_CORE);
   c_err: cover property (RATIO_RANGE_ERR);

endmodule : mcfd_top

// *** mcfd_host_model.sv ***
// partner: serial management host that writes and reads configuration fields
`timescale 1ns/1ns
module mcfd_host_model (
   // clock
   input wire logic clk,
   // register port toward the device
   output logic [7:0] reg_addr,
   output logic [15:0] reg_wdata,
   output logic reg_we,
   output logic reg_re,
   input wire logic [15:0] reg_rdata,
   input wire logic reg_rvalid
);
   import mcfd_pkg::*;

   initial begin
      reg_addr = 8'h00;
      reg_wdata = 16'h0000;
      reg_we = 1'b0;
      reg_re = 1'b0;
   end

   // one word per write; bad lets a test break the response field band on purpose
   task automatic wr(input logic [7:0] a, input logic [15:0] d, input bit bad = 1'b0);
      @(posedge clk);
      #1;
      if (a == OFS_RESP && !bad && (d[5:0] < RATIO_MIN || d[5:0] > RATIO_MAX)) begin
         d[5:0] = RATIO_MIN;
      end
      reg_addr = a;
      reg_wdata = d;
      reg_we = 1'b1;
      @(posedge clk);
      #1;
      reg_we = 1'b0;
      reg_wdata = ~d;
   endtask : wr

   // write then read the same offset on the very next edge; caller keeps d legal
   task automatic wrrd(input logic [7:0] a, input logic [15:0] d, output logic [15:0] q,
      output logic v);
      @(posedge clk);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_we = 1'b1;
      @(posedge clk);
      #1;
      reg_we = 1'b0;
      reg_re = 1'b1;
      @(posedge clk);
      #1;
      reg_re = 1'b0;
      reg_wdata = ~d;
      q = reg_rdata;
      v = reg_rvalid;
   endtask : wrrd

   // answer is taken one edge after the request
   task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic v);
      @(posedge clk);
      #1;
      reg_addr = a;
      reg_re = 1'b1;
      @(posedge clk);
      #1;
      reg_re = 1'b0;
      d = reg_rdata;
      v = reg_rvalid;
   endtask : rd
endmodule : mcfd_host_model

// *** motor_config_field_decode_tb_top.sv ***
// testbench: register readback and decoded settings of the motor configuration block
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin n_errors++; \
   $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module motor_config_field_decode_tb_top;
   import mcfd_pkg::*;
   logic ref_clk, resetn, we, re, rvalid, spd_pin, spd_lvl, tach_core, tach_out;
   logic [7:0] addr, p_gain, i_gain, nudge;
   logic [15:0] wdata, rdata, d;
   logic [13:0] acc_rate;
   logic closed, abc, analog, clk_in, pwm_in, low_band, ratio_err, v;
   logic [5:0] resp_tc, clk_ratio;
   logic [4:0] off_pct, m;
   logic [12:0] ipd_ma;
   mcfd_start_t start_m;
   int n_errors = 0;
   int n_checks = 0;
   logic [7:0] offs [10] = '{OFS_SPEED_DIR, OFS_ACCEL, OFS_INPUT_TYPE, OFS_STARTUP,
      OFS_P_GAIN, OFS_I_GAIN, OFS_OUT_PIN, OFS_POS_DET, OFS_IN_THR, OFS_RESP};
   logic [4:0] off_tab [4] = '{5'h0A, 5'h06, 5'h0F, 5'h14};
   logic [7:0] code;
   logic [1:0] st;
   logic [15:0] sd;

   mcfd_host_model host (.clk(ref_clk), .reg_addr(addr), .reg_wdata(wdata), .reg_we(we),
      .reg_re(re), .reg_rdata(rdata), .reg_rvalid(rvalid));

   mcfd_top dut (.REF_CLK(ref_clk), .RESETN(resetn), .REG_ADDR(addr), .REG_WDATA(wdata),
      .REG_WE(we), .REG_RE(re), .REG_RDATA(rdata), .REG_RVALID(rvalid),
      .SPEED_IN_PIN(spd_pin), .SPEED_IN_LEVEL(spd_lvl), .TACH_CORE(tach_core),
      .TACH_OUT(tach_out), .ACCEL_RATE(acc_rate), .CLOSED_LOOP(closed),
      .PHASE_ORDER_ABC(abc), .ANALOG_INPUT(analog), .CLOCK_INPUT(clk_in),
      .PWM_INPUT(pwm_in), .PWM_LOW_BAND(low_band), .RESPONSE_TC(resp_tc),
      .CLOCK_RATIO(clk_ratio), .RATIO_RANGE_ERR(ratio_err), .OFF_THRESHOLD_PCT(off_pct),
      .STARTUP_METHOD(start_m), .PULSE_DETECT_CURRENT_LIMIT_MA(ipd_ma),
      .NUDGE_AMPLITUDE(nudge), .OBSERVER_PROPORTIONAL_GAIN(p_gain),
      .OBSERVER_INTEGRAL_GAIN(i_gain));

   // ----------------------------------------
   // clock, reset and helpers
   // ----------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   task automatic settle();
      repeat (2) @(posedge ref_clk);
      #1;
   endtask : settle

   task automatic done(input string nm);
      $display("test %s done", nm);
   endtask : done

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : give_verdict

   initial begin
      #60000;
      n_errors++;
      give_verdict();
   end

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      resetn = 1'b0;
      spd_pin = 1'b0;
      tach_core = 1'b0;
      repeat (8) @(posedge ref_clk);
      #1;
      resetn = 1'b1;
      settle();
      for (int i = 0; i < 10; i++) begin
         host.rd(offs[i], d, v);
         `CHK("reset value", 16'h0000, d)
      end
      `CHK("off pct reset", 5'h0A, off_pct)
      `CHK("pwm reset", 1'b1, pwm_in)
      done("reset");

      for (int i = 0; i < 10; i++) host.wr(offs[i], {offs[i], ~offs[i]});
      host.wr(8'h10, 16'hFFFF);
      for (int i = 0; i < 10; i++) begin
         host.rd(offs[i], d, v);
         `CHK("readback valid", 1'b1, v)
         `CHK("readback", {offs[i], ~offs[i]}, d)
      end
      host.rd(8'h10, d, v);
      `CHK("unmapped", 16'h0000, d)
      @(posedge ref_clk);
      #1;
      `CHK("valid pulse", 1'b0, rvalid)
      host.wrrd(OFS_RESP, 16'h5A21, d, v);
      `CHK("write then read valid", 1'b1, v)
      `CHK("write then read", 16'h5A21, d)
      done("readback");

      for (int i = 0; i < 6; i++) begin
         code = (i % 3 == 0) ? 8'h00 : ((i % 3 == 1) ? 8'h01 : 8'hFF);
         host.wr(OFS_SPEED_DIR, (i >= 3) ? 16'h2000 : 16'h0000);
         host.wr(OFS_ACCEL, {8'h00, code});
         settle();
         `CHK("accel", (i >= 3) ? {code, 6'h00} : {6'h00, code}, acc_rate)
      end
      done("accel");

      host.wr(OFS_RESP, 16'h0029);
      for (int i = 0; i < 32; i++) begin
         m = i[4:0];
         sd = 16'h0000;
         sd[B_CLOSED_LOOP] = m[0];
         sd[B_CLOCK_KIND] = m[1];
         sd[B_DIRECTION] = m[2];
         sd[B_PWM_BAND] = m[3];
         host.wr(OFS_SPEED_DIR, sd);
         host.wr(OFS_INPUT_TYPE, {4'h0, m[4], 11'h000});
         settle();
         `CHK("closed", m[0], closed)
         `CHK("order", m[2], abc)
         `CHK("analog", m[4], analog)
         `CHK("clock", !m[4] && m[1], clk_in)
         `CHK("pwm", !m[4] && !m[1], pwm_in)
         `CHK("band", m[3], low_band)
         `CHK("resp tc", m[0] ? 6'h29 : 6'h00, resp_tc)
         `CHK("ratio", (!m[4] && m[1]) ? 6'h29 : 6'h00, clk_ratio)
         `CHK("range ok", 1'b0, ratio_err)
      end
      done("modes");

      host.wr(OFS_SPEED_DIR, 16'h0800);
      host.wr(OFS_RESP, 16'h0000, 1'b1);
      settle();
      `CHK("range low", 1'b1, ratio_err)
      host.wr(OFS_RESP, 16'h002A, 1'b1);
      settle();
      `CHK("range high", 1'b1, ratio_err)
      host.wr(OFS_RESP, 16'h0001);
      settle();
      `CHK("range min", 1'b0, ratio_err)
      `CHK("tc min", 6'h01, resp_tc)
      done("range");

      for (int i = 0; i < 12; i++) begin
         st = (i < 8) ? 2'b10 : i[1:0];
         code = (i < 8) ? i[7:0] : 8'h07;
         host.wr(OFS_STARTUP, {4'h0, st, 10'h000});
         host.wr(OFS_IN_THR, {6'h00, code[1:0], code[2:0], 5'h00});
         settle();
         `CHK("start", st, start_m)
         `CHK("off pct", off_tab[code[1:0]], off_pct)
         `CHK("nudge", (st == 2'b10) ? code * 8'h20 + 8'h18 : 8'h00, nudge)
      end
      done("startup");

      for (int i = 0; i < 3; i++) begin
         code = (i == 0) ? 8'h01 : ((i == 1) ? 8'h3F : 8'h00);
         host.wr(OFS_POS_DET, {2'b00, code[5:0], 8'h00});
         settle();
         `CHK("ipd", {5'h00, code} * 13'h0056, ipd_ma)
      end
      host.wr(OFS_P_GAIN, 16'h12A5);
      host.wr(OFS_I_GAIN, 16'h345A);
      settle();
      `CHK("p gain", 8'hA5, p_gain)
      `CHK("i gain", 8'h5A, i_gain)
      done("gains");

      host.wr(OFS_OUT_PIN, 16'h0000);
      settle();
      for (int i = 0; i < 4; i++) begin
         tach_core = i[0];
         @(posedge ref_clk);
         #1;
         `CHK("tach follow", i[0], tach_out)
      end
      host.wr(OFS_OUT_PIN, 16'h0010);
      settle();
      for (int i = 0; i < 4; i++) begin
         tach_core = i[0];
         @(posedge ref_clk);
         #1;
         `CHK("tach held", 1'b1, tach_out)
      end
      done("tach");

      spd_pin = 1'b1;
      repeat (3) @(posedge ref_clk);
      #1;
      `CHK("pin latency", 1'b0, spd_lvl)
      @(posedge ref_clk);
      #1;
      `CHK("pin level", 1'b1, spd_lvl)
      spd_pin = 1'b0;
      @(posedge ref_clk);
      #1;
      spd_pin = 1'b1;
      for (int i = 0; i < 5; i++) begin
         @(posedge ref_clk);
         #1;
         `CHK("pin glitch", 1'b1, spd_lvl)
      end
      done("pin");
      give_verdict();
   end
endmodule : motor_config_field_decode_tb_top
